//--- inc/ctrl_sync_pkg.sv
// Purpose: shared constants and types of the control synchronizer
// Assumes: packet type sits in the low nibble of plane 0 of the header beat
// Notes:   control packet body carries one nibble in the low bits of each plane
`default_nettype none
package ctrl_sync_pkg;
  localparam logic [3:0] TYPE_VIDEO   = 4'h0;   // video data packet
  localparam logic [3:0] TYPE_CTRL    = 4'hF;   // control data packet
  localparam int         NIB_W        = 4;      // bits of one control nibble
  localparam int         DIM_W        = 16;     // width and height field size
  localparam int         W_NIBS       = 4;      // nibbles 0..3 hold the width
  localparam int         H_END        = 8;      // nibbles 4..7 hold the height
  localparam logic [3:0] NIB_CNT_MAX  = 4'hF;   // nibble counter saturates here
  localparam int         MM_ADDR_W    = 32;     // master address width
  localparam int         MM_DATA_W    = 32;     // master data width
  localparam int         MAX_WRITES   = 8;      // default depth of the write table

  // one-bit steps along pass -> write -> finish; finish -> pass flips both bits
  typedef enum logic [1:0] {
    ST_PASS   = 2'h0,
    ST_WRITE  = 2'h1,
    ST_FINISH = 2'h3
  } sync_state_t;
endpackage
`default_nettype wire

//--- core/ctrl_sync.sv
// Purpose: stream pass-through that stalls on trigger events and writes stored
//          data words to stored addresses over a memory-mapped master
// Assumes: bits per sample of at least four; targets raise waitrequest to hold
// Notes:   a two-entry buffer sits between input and output; outputs are flops
//
// Functional notes
// - forward every packet unchanged while inspecting
// - trigger on video start or size change
// - stall the stream immediately on a trigger
// - write each of the first num_writes stored words to its address
// - resume only after all writes finish
// - writes finish before the video packet leaves
// - pulse completion when all writes are done
// - enable location gates every trigger
// - one-shot option clears enable after trigger
// - frame size and format taken at run time
// - up to four planes in parallel, any sequential
// - bits per sample is a build parameter
`timescale 1ns/100ps
`default_nettype none
module ctrl_sync #(
  parameter int PLANES   = 3,                       // planes in parallel, 1 to 4
  parameter int BPS      = 8,                       // bits per color sample
  parameter int N_WR     = ctrl_sync_pkg::MAX_WRITES,
  parameter bit ONE_SHOT = 1'b0                     // disable trigger after each event
) (
  input  wire logic                              clk_sys,
  input  wire logic                              reset_n,
  // stream input
  input  wire logic [PLANES*BPS-1:0]             in_data,
  input  wire logic                              in_sop,
  input  wire logic                              in_eop,
  input  wire logic                              in_valid,
  output var  logic                              in_ready,
  // stream output
  output var  logic [PLANES*BPS-1:0]             out_data,
  output var  logic                              out_sop,
  output var  logic                              out_eop,
  output var  logic                              out_valid,
  input  wire logic                              out_ready,
  // write table load port
  input  wire logic                              tbl_wr,
  input  wire logic [$clog2(N_WR)-1:0]           tbl_index,
  input  wire logic [ctrl_sync_pkg::MM_ADDR_W-1:0] tbl_address,
  input  wire logic [ctrl_sync_pkg::MM_DATA_W-1:0] tbl_data,
  input  wire logic [$clog2(N_WR+1)-1:0]         num_writes,
  // trigger control and status
  input  wire logic                              trig_en_wr,
  input  wire logic                              trig_en_data,
  input  wire logic                              trig_on_size,
  output var  logic                              trig_enabled,
  output var  logic                              stalled,
  output var  logic                              writes_done,
  // memory-mapped master
  output var  logic [ctrl_sync_pkg::MM_ADDR_W-1:0] mm_address,
  output var  logic [ctrl_sync_pkg::MM_DATA_W-1:0] mm_writedata,
  output var  logic                              mm_write,
  input  wire logic                              mm_waitrequest
);
  localparam int DW = PLANES * BPS;
  localparam int EW = DW + 2;                 // data plus sop and eop
  localparam int IW = $clog2(N_WR);
  localparam int CW = $clog2(N_WR + 1);

  ctrl_sync_pkg::sync_state_t state;
  ctrl_sync_pkg::sync_state_t next_state;

  logic [ctrl_sync_pkg::MM_ADDR_W-1:0] addr_mem [N_WR];
  logic [ctrl_sync_pkg::MM_DATA_W-1:0] data_mem [N_WR];

  logic [EW-1:0] head, skid, next_head, next_skid;
  logic          head_v, skid_v, next_head_v, next_skid_v;
  logic          push, pop, trig_fire, next_stall;
  logic [IW-1:0] wr_idx;
  logic [CW-1:0] wr_total;
  logic          last_ack;

  logic                      in_ctrl;
  logic [3:0]                nib_cnt;
  logic [ctrl_sync_pkg::DIM_W-1:0] width_acc, height_acc, next_width, next_height;
  logic [ctrl_sync_pkg::DIM_W-1:0] cur_width, cur_height;
  logic                      size_pending, size_changed;
  logic [ctrl_sync_pkg::NIB_W-1:0] nib [PLANES];

  // per-plane nibble of a control packet body beat
  genvar gp;
  generate
    for (gp = 0; gp < PLANES; gp++) begin : g_nib
      assign nib[gp] = in_data[gp*BPS +: ctrl_sync_pkg::NIB_W];
    end
  endgenerate

  assign push = in_valid & in_ready;
  assign pop  = out_valid & out_ready;

  // video header taken while armed; the header stays in the buffer, so the new
  // settings land before any beat of that packet leaves
  assign trig_fire = push & in_sop & (state == ctrl_sync_pkg::ST_PASS) & trig_enabled
                   & (in_data[ctrl_sync_pkg::NIB_W-1:0] == ctrl_sync_pkg::TYPE_VIDEO)
                   & (~trig_on_size | size_pending);

  assign last_ack = mm_write & ~mm_waitrequest & (CW'(wr_idx) == CW'(wr_total - 1'b1));

  // control packet width and height assembly, plane 0 carries the first nibble of each beat
  always_comb begin
    int k;
    k = 0;
    next_width  = width_acc;
    next_height = height_acc;
    for (int p = 0; p < PLANES; p++) begin
      k = int'(nib_cnt) + p;
      if (in_ctrl && !in_sop) begin
        if (k < ctrl_sync_pkg::W_NIBS) begin
          next_width[ctrl_sync_pkg::DIM_W-1-ctrl_sync_pkg::NIB_W*k -: ctrl_sync_pkg::NIB_W] = nib[p];
        end else if (k < ctrl_sync_pkg::H_END) begin
          next_height[ctrl_sync_pkg::DIM_W-1-ctrl_sync_pkg::NIB_W*(k-ctrl_sync_pkg::W_NIBS)
                      -: ctrl_sync_pkg::NIB_W] = nib[p];
        end
      end
    end
  end

  assign size_changed = push & in_ctrl & in_eop & ((next_width != cur_width) | (next_height != cur_height));

  // parser state follows every accepted beat; sizes are learnt at run time
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      in_ctrl    <= 1'b0;
      nib_cnt    <= 4'h0;
      width_acc  <= '0;
      height_acc <= '0;
      cur_width  <= '0;
      cur_height <= '0;
    end else if (push) begin
      if (in_sop) begin
        in_ctrl <= (in_data[ctrl_sync_pkg::NIB_W-1:0] == ctrl_sync_pkg::TYPE_CTRL);
        nib_cnt <= 4'h0;
      end else if (in_ctrl) begin
        width_acc  <= next_width;
        height_acc <= next_height;
        if (nib_cnt > ctrl_sync_pkg::NIB_CNT_MAX - 4'(PLANES)) nib_cnt <= ctrl_sync_pkg::NIB_CNT_MAX;
        else nib_cnt <= nib_cnt + 4'(PLANES);
      end
      if (in_ctrl && in_eop) begin
        in_ctrl    <= 1'b0;
        cur_width  <= next_width;
        cur_height <= next_height;
      end
    end
  end

  // pending size change: a new change wins over the clear by a trigger
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) size_pending <= 1'b0;
    else if (size_changed) size_pending <= 1'b1;
    else if (trig_fire) size_pending <= 1'b0;
  end

  // trigger enable; the one-shot disable wins over a same-cycle software write
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) trig_enabled <= 1'b0;
    else if (ONE_SHOT && trig_fire) trig_enabled <= 1'b0;
    else if (trig_en_wr) trig_enabled <= trig_en_data;
  end

  // write table, loaded by software at any time
  always_ff @(posedge clk_sys) begin
    if (tbl_wr) begin
      addr_mem[tbl_index] <= tbl_address;
      data_mem[tbl_index] <= tbl_data;
    end
  end

  // sequencer: pass, write the first num_writes entries, one finishing cycle, pass
  always_comb begin
    next_state = state;
    case (state)
      ctrl_sync_pkg::ST_PASS:   if (trig_fire) next_state = (num_writes == '0) ? ctrl_sync_pkg::ST_FINISH
                                                                            : ctrl_sync_pkg::ST_WRITE;
      ctrl_sync_pkg::ST_WRITE:  if (last_ack) next_state = ctrl_sync_pkg::ST_FINISH;
      ctrl_sync_pkg::ST_FINISH: next_state = ctrl_sync_pkg::ST_PASS;
      default:                  next_state = ctrl_sync_pkg::ST_PASS;
    endcase
  end
  assign next_stall = (next_state != ctrl_sync_pkg::ST_PASS);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state       <= ctrl_sync_pkg::ST_PASS;
      stalled     <= 1'b0;
      writes_done <= 1'b0;
    end else begin
      state       <= next_state;
      stalled     <= next_stall;
      writes_done <= (state == ctrl_sync_pkg::ST_FINISH);
    end
  end

  // master: one write at a time, held while the target waits
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mm_write     <= 1'b0;
      mm_address   <= '0;
      mm_writedata <= '0;
      wr_idx       <= '0;
      wr_total     <= '0;
    end else if (trig_fire && num_writes != '0) begin
      mm_write     <= 1'b1;
      mm_address   <= addr_mem[0];
      mm_writedata <= data_mem[0];
      wr_idx       <= '0;
      wr_total     <= num_writes;                                  // count frozen per trigger
    end else if (mm_write && !mm_waitrequest) begin
      if (last_ack) begin
        mm_write <= 1'b0;
      end else begin
        mm_address   <= addr_mem[wr_idx + 1'b1];
        mm_writedata <= data_mem[wr_idx + 1'b1];
        wr_idx       <= wr_idx + 1'b1;
      end
    end
  end

  // two-entry buffer: head drives the outputs directly, skid absorbs a late stall
  always_comb begin
    next_head   = head;
    next_skid   = skid;
    next_head_v = head_v;
    next_skid_v = skid_v;
    if (pop) begin
      if (skid_v) begin
        next_head   = skid;
        next_skid_v = 1'b0;
      end else begin
        next_head_v = 1'b0;
      end
    end
    if (push) begin
      if (!next_head_v) begin
        next_head   = {in_sop, in_eop, in_data};
        next_head_v = 1'b1;
      end else begin
        next_skid   = {in_sop, in_eop, in_data};
        next_skid_v = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      head      <= '0;
      skid      <= '0;
      head_v    <= 1'b0;
      skid_v    <= 1'b0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      head      <= next_head;
      skid      <= next_skid;
      head_v    <= next_head_v;
      skid_v    <= next_skid_v;
      in_ready  <= ~next_skid_v & ~next_stall;
      out_valid <= next_head_v & ~next_stall;
    end
  end
  assign out_data = head[DW-1:0];
  assign out_eop  = head[DW];
  assign out_sop  = head[DW+1];

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  trigger_stall_a: assert property (trig_fire |=> stalled && !in_ready && !out_valid)
    else $error("trigger did not stall the stream");
  stall_quiet_a: assert property ((state != ctrl_sync_pkg::ST_PASS) |-> !in_ready && !out_valid)
    else $error("stream moved while stalled");
  master_hold_a: assert property (mm_write && mm_waitrequest |=> mm_write && $stable(mm_address)
                                   && $stable(mm_writedata))
    else $error("master request changed during wait");
  done_pulse_a: assert property (last_ack |=> ##1 writes_done ##1 !writes_done)
    else $error("completion pulse missing or long");
  resume_after_a: assert property (mm_write |-> stalled)
    else $error("stream resumed before writes finished");
  disabled_quiet_a: assert property (!trig_enabled && state == ctrl_sync_pkg::ST_PASS
                                     |=> state == ctrl_sync_pkg::ST_PASS)
    else $error("trigger acted while disabled");
  one_shot_a: assert property (ONE_SHOT && trig_fire |=> !trig_enabled)
    else $error("one-shot did not disable trigger");
  size_seen_a: assert property (size_changed |=> size_pending)
    else $error("size change not recorded");
  out_hold_a: assert property (out_valid && !out_ready |=> $stable(out_data) && (out_valid || stalled))
    else $error("output word dropped under back-pressure");
  write_first_a: assert property (trig_fire && num_writes != '0 |=> mm_write && wr_idx == '0)
    else $error("write sequence did not start at entry zero");

  trig_c:  cover property (trig_fire ##[1:50] writes_done);
  full_c:  cover property (skid_v && head_v && !out_ready);
  size_c:  cover property (size_changed ##[1:200] trig_fire);
  wait_c:  cover property ((mm_write && mm_waitrequest) [*2]);
endmodule  // ctrl_sync
`default_nettype wire

//--- sim/mm_target.sv
// Purpose: memory-mapped target model that logs every write it accepts
// Assumes: one write outstanding at a time; waitrequest high holds the master
// Notes:   wait_n stall cycles per write, 0 accepts at once
`timescale 1ns/100ps
`default_nettype none
module mm_target (
  input  wire logic        clk_sys,
  input  wire logic [31:0] mm_address,
  input  wire logic [31:0] mm_writedata,
  input  wire logic        mm_write,
  input  wire logic [3:0]  wait_n,
  output var  logic        mm_waitrequest,
  output var  logic [5:0]  log_n,
  output var  logic [5:0]  hold_err
);
  logic [31:0] log_a [64];
  logic [31:0] log_d [64];
  logic [63:0] held;
  logic        was_held;
  logic [3:0]  wcnt;
  initial begin
    mm_waitrequest = 1'b0;
    log_n = '0;
    hold_err = '0;
    wcnt = '0;
    was_held = 1'b0;
  end
  // answer off the sampling edge; bounded wait so the master always gets through
  always @(negedge clk_sys) begin
    mm_waitrequest <= mm_write && (wcnt < wait_n);
  end
  // a held request must not move; accepted writes go to the log in order
  always @(posedge clk_sys) begin
    if (mm_write && was_held && {mm_address, mm_writedata} !== held) hold_err <= hold_err + 6'h01;
    was_held <= mm_write && mm_waitrequest;
    held <= {mm_address, mm_writedata};
    if (mm_write && mm_waitrequest) begin
      wcnt <= wcnt + 4'h1;
    end else if (mm_write) begin
      log_a[log_n] <= mm_address;
      log_d[log_n] <= mm_writedata;
      log_n <= log_n + 6'h01;
      wcnt <= '0;
    end
  end
endmodule // mm_target
`default_nettype wire

//--- sim/test_ctrl_sync.sv
// Purpose: self-checking bench for the control synchronizer
// Assumes: PLANES 3, BPS 8, eight table entries; inputs change at the falling edge
// Notes:   output beats and trigger writes are compared per test
`timescale 1ns/100ps
`default_nettype none
module test_ctrl_sync;
  logic        clk_sys, reset_n, in_sop, in_eop, in_valid, in_ready, out_sop, out_eop, out_valid, out_ready;
  logic [23:0] in_data, out_data;
  logic [31:0] tbl_address, tbl_data, mm_address, mm_writedata;
  logic [2:0]  tbl_index;
  logic [3:0]  num_writes, wait_n;
  logic        tbl_wr, trig_en_wr, trig_en_data, trig_on_size, trig_enabled, stalled, writes_done;
  logic        mm_write, mm_waitrequest, stall_mode, once_en;
  logic [5:0]  log_n, hold_err;
  logic [25:0] exp_q[$], out_q[$];
  logic [15:0] cyc;
  int          error_cnt, cmp_count, done_cnt, exp_log, wr_at_sop, stall_cnt;

  ctrl_sync #(.PLANES(3), .BPS(8), .N_WR(8), .ONE_SHOT(1'b0)) i_ctrl_sync (.clk_sys, .reset_n, .in_data, .in_sop,
    .in_eop, .in_valid, .in_ready, .out_data, .out_sop, .out_eop, .out_valid, .out_ready, .tbl_wr, .tbl_index,
    .tbl_address, .tbl_data, .num_writes, .trig_en_wr, .trig_en_data, .trig_on_size, .trig_enabled, .stalled,
    .writes_done, .mm_address, .mm_writedata, .mm_write, .mm_waitrequest);
  mm_target i_mm_target (.clk_sys, .mm_address, .mm_writedata, .mm_write, .wait_n, .mm_waitrequest, .log_n,
    .hold_err);

  // one-shot copy on the same inputs; only its enable is watched, its stream and master run free
  ctrl_sync #(.PLANES(3), .BPS(8), .N_WR(8), .ONE_SHOT(1'b1)) i_ctrl_sync_once (.clk_sys, .reset_n, .in_data,
    .in_sop, .in_eop, .in_valid, .in_ready(), .out_data(), .out_sop(), .out_eop(), .out_valid(), .out_ready,
    .tbl_wr, .tbl_index, .tbl_address, .tbl_data, .num_writes, .trig_en_wr, .trig_en_data, .trig_on_size,
    .trig_enabled(once_en), .stalled(), .writes_done(), .mm_address(), .mm_writedata(), .mm_write(),
    .mm_waitrequest);

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // collect at the rising edge that takes the beat; the outputs still hold what that edge samples
  always @(posedge clk_sys) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      out_q.push_back({out_sop, out_eop, out_data});
      if (out_sop && out_data[3:0] === ctrl_sync_pkg::TYPE_VIDEO) wr_at_sop = log_n;
    end
  end

  // status counts and receiver back-pressure at the falling edge
  always @(negedge clk_sys) begin
    if (writes_done === 1'b1) done_cnt++;
    if (stalled === 1'b1) begin
      check({30'h0, out_valid, in_ready}, 32'h0);
      stall_cnt++;
    end
    cyc = cyc + 16'h1;
    out_ready <= !(stall_mode && cyc[1]); // receiver stalls half the time to fill the buffer
  end

  task automatic put(input logic [23:0] d, input logic s, input logic e);
    in_data = d;
    in_sop = s;
    in_eop = e;
    in_valid = 1'b1;
    exp_q.push_back({s, e, d});
    while (in_ready !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
  endtask

  // control bodies carry width then height, one nibble per plane, upper nibble junk
  task automatic pkt(input logic [3:0] typ, input logic [15:0] w, input logic [15:0] h, input int n);
    logic [31:0] nibs;
    logic [23:0] d;
    nibs = {w, h};
    put({16'h5A5A, 4'hC, typ}, 1'b1, 1'b0);
    for (int k = 0; k < n; k++) begin
      for (int p = 0; p < 3; p++)
        d[p*8 +: 8] = (typ == ctrl_sync_pkg::TYPE_CTRL && 3*k+p < 8) ? {4'hB, nibs[31-4*(3*k+p) -: 4]} : 8'(3*k+p);
      put(d, 1'b0, k == n-1);
    end
    in_valid = 1'b0;
  endtask

  task automatic set_en(input logic v);
    trig_en_wr = 1'b1;
    trig_en_data = v;
    @(negedge clk_sys);
    trig_en_wr = 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic end_test(input string name, input int nwr, input int ndone, input int nstall);
    for (int i = 0; i < 300 && out_q.size() < exp_q.size(); i++) @(negedge clk_sys);
    while (exp_q.size() > 0 && out_q.size() > 0) check(32'(out_q.pop_front()), 32'(exp_q.pop_front()));
    check(32'(out_q.size() + exp_q.size()), 32'h0);
    for (int i = 0; i < nwr; i++) begin
      check(i_mm_target.log_a[exp_log+i], 32'h8000_0100 + 32'(4*(i%3)));
      check(i_mm_target.log_d[exp_log+i], 32'hD000_0000 + 32'(i%3));
    end
    exp_log += nwr;
    check(32'(log_n), 32'(exp_log));
    check(32'(wr_at_sop), 32'(exp_log));
    check(32'(done_cnt), 32'(ndone));
    check(32'(stall_cnt), 32'(nstall));
    check(32'(hold_err), 32'h0);
    done_cnt = 0;
    stall_cnt = 0;
    $display("test %s done", name);
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // tests need about 200 cycles; cut off a hang well after that
  initial begin
    #(100 * 20000);
    error_cnt++;
    summarize();
  end

  initial begin
    {reset_n, in_data, in_sop, in_eop, in_valid, out_ready, tbl_wr, tbl_index, tbl_address, tbl_data} = '0;
    {num_writes, trig_en_wr, trig_en_data, trig_on_size, wait_n, stall_mode, cyc} = '0;
    repeat (20) @(negedge clk_sys);
    reset_n = 1'b1;
    @(negedge clk_sys);
    check(32'(trig_enabled), 32'h0);
    for (int i = 0; i < 8; i++) begin
      tbl_wr = 1'b1;
      tbl_index = 3'(i);
      tbl_address = 32'h8000_0100 + 32'(4*i);
      tbl_data = 32'hD000_0000 + 32'(i);
      @(negedge clk_sys);
    end
    tbl_wr = 1'b0;
    num_writes = 4'h3;
    stall_mode = 1'b1;
    pkt(ctrl_sync_pkg::TYPE_CTRL, 16'd320, 16'd240, 3);
    pkt(ctrl_sync_pkg::TYPE_VIDEO, 16'h0, 16'h0, 4);
    end_test("pass_disabled", 0, 0, 0);
    set_en(1'b1);
    check(32'(trig_enabled), 32'h1);
    check(32'(once_en), 32'h1);
    wait_n = 4'h2;
    pkt(ctrl_sync_pkg::TYPE_VIDEO, 16'h0, 16'h0, 5);
    check(32'(once_en), 32'h0);
    check(32'(trig_enabled), 32'h1);
    pkt(ctrl_sync_pkg::TYPE_VIDEO, 16'h0, 16'h0, 1);
    // two triggers of three writes, each write two wait cycles and an accept cycle, plus the finishing cycle
    end_test("video_trigger", 6, 2, 20);
    trig_on_size = 1'b1;
    wait_n = 4'h0;
    stall_mode = 1'b0;
    pkt(ctrl_sync_pkg::TYPE_CTRL, 16'd640, 16'd480, 3);
    pkt(ctrl_sync_pkg::TYPE_VIDEO, 16'h0, 16'h0, 2);
    pkt(ctrl_sync_pkg::TYPE_CTRL, 16'd640, 16'd480, 3);
    pkt(ctrl_sync_pkg::TYPE_VIDEO, 16'h0, 16'h0, 2);
    pkt(ctrl_sync_pkg::TYPE_CTRL, 16'd640, 16'd360, 3);
    pkt(ctrl_sync_pkg::TYPE_VIDEO, 16'h0, 16'h0, 2);
    end_test("size_trigger", 6, 2, 8);
    trig_on_size = 1'b0;
    num_writes = 4'h0;
    pkt(ctrl_sync_pkg::TYPE_VIDEO, 16'h0, 16'h0, 3);
    end_test("zero_writes", 0, 1, 1);
    set_en(1'b0);
    num_writes = 4'h3;
    pkt(ctrl_sync_pkg::TYPE_VIDEO, 16'h0, 16'h0, 2);
    end_test("disabled_again", 0, 0, 0);
    summarize();
  end
endmodule // test_ctrl_sync
`default_nettype wire
